// ---- act_clk_div.sv ----
// Conversion clock divider: toggles after prescale plus one bus cycles
`default_nettype none
module act_clk_div (
    input  wire logic clock,
    input  wire logic rst_b,
    act_div_if.div    dv
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic       clk_q;
    logic       clk_d;
    wire        atEnd = (cnt_q == dv.prescale);

    assign cnt_d   = dv.clear ? 5'h00 : (!dv.run ? cnt_q : (atEnd ? 5'h00 : cnt_q + 5'h01));
    assign clk_d   = dv.clear ? 1'b0 : ((dv.run && atEnd) ? !clk_q : clk_q);
    // One tick per conversion clock period, on the rising toggle
    assign dv.tick    = dv.run && !dv.clear && atEnd && !clk_q;
    assign dv.convClk = clk_q;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= 5'h00;
            clk_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d; // [RULE6]
            clk_q <= clk_d; // [RULE6]
        end
    end

    a_div_reload: assert property (@(posedge clock) disable iff (!rst_b) // [RULE6]
        (dv.run && !dv.clear && atEnd) |=> (clk_q != $past(clk_q)) && (cnt_q == 5'h00))
        else $error("divider did not reload at prescale end");
    a_div_clear: assert property (@(posedge clock) disable iff (!rst_b) // [RULE10]
        dv.clear |=> (cnt_q == 5'h00) && !clk_q)
        else $error("divider not restarted by clear");
endmodule // act_clk_div
`default_nettype wire

// ---- act_core_model.sv ----
// Behavioural model of the analog core that returns compare results
`default_nettype none
module act_core_model (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic convertActive,
    input  wire logic matchEn,
    output logic      compareMatch
);
    timeunit 1ns;
    timeprecision 1ps;
    logic churn_q;
    // Result is only meaningful in the convert phase, so it churns elsewhere
    always_ff @(posedge clock or negedge rst_b)
        if (!rst_b)
            churn_q <= 1'b0;
        else
            churn_q <= ~churn_q;
    assign compareMatch = convertActive ? matchEn : churn_q;
endmodule // act_core_model
`default_nettype wire

// ---- act_div_if.sv ----
// Interface: sequencer to conversion clock divider
`default_nettype none
interface act_div_if;
    logic       clear;
    logic       run;
    logic [4:0] prescale;
    logic       tick;
    logic       convClk;
    modport ctl (output clear, output run, output prescale, input tick, input convClk);
    modport div (input clear, input run, input prescale, output tick, output convClk);
endinterface
`default_nettype wire

// ---- act_pkg.sv ----
// Package: constants, register map and types of the conversion timing control
`default_nettype none
package act_pkg;
    // ************************************************************
    // Register map (byte addresses on the bus)
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_TIMING = 8'h04;
    localparam logic [7:0] ADDR_DIEN   = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_MASK   = 8'h10;
    localparam logic [7:0] ADDR_STATE  = 8'h14;
    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CTRL_ENABLE   = 0;
    localparam int CTRL_START    = 1;
    localparam int CTRL_SEQ_IE   = 2;
    localparam int CTRL_CMP_IE   = 3;
    localparam int CTRL_FRZ_LO   = 4;
    localparam int CTRL_FRZ_HI   = 5;
    localparam int STAT_SEQ_DONE = 0;
    localparam int STAT_COMPARE  = 1;
    localparam int TIM_PRS_LSB   = 0;
    localparam int TIM_SMP_LSB   = 5;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [7:0] DIEN_RESET   = 8'h00;
    localparam logic [1:0] MASK_RESET   = 2'h0;
    // ************************************************************
    // Sequence shape: conversion length in conversion clock cycles, index of the last conversion
    // ************************************************************
    localparam logic [4:0] CONV_CYCLES = 5'h0a;
    localparam logic [1:0] SEQ_LAST    = 2'h3;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {FRZ_OFF, FRZ_RSVD, FRZ_FINISH, FRZ_IMM} act_frz_e;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV} act_state_e;

    // Sampling phase length for a sample-time select code
    function automatic logic [4:0] smpLen(input logic [2:0] sel);
        case (sel)
            3'h0:    smpLen = 5'h04;
            3'h1:    smpLen = 5'h06;
            3'h2:    smpLen = 5'h08;
            3'h3:    smpLen = 5'h0a;
            3'h4:    smpLen = 5'h0c;
            3'h5:    smpLen = 5'h10;
            3'h6:    smpLen = 5'h14;
            default: smpLen = 5'h18;
        endcase
    endfunction
endpackage
`default_nettype wire

// ---- act_top.sv ----
// Conversion timing and control block with a Wishbone register slave
//
// Added by the designer: the Wishbone interface to the registers.
`default_nettype none
// Function
// [RULE1] Debug freeze: 10 finish conversion, 11 immediate
// [RULE2] Timing register write aborts running sequence
// [RULE3] Sample select bits 7..5 set sampling length
// [RULE4] Codes give 4,6,8,10,12,16,20,24 conversion clocks
// [RULE5] Bits 4..0 hold five-bit prescale value
// [RULE6] Conversion clock is bus over 2*(prescale+1)
// [RULE7] Reset leaves converter powered down, defined bits
// [RULE8] Each interrupt gated by its local enable
// [RULE9] Per-pin digital input buffer enable mask
// [RULE10] Abort returns idle, restarts prescaler from zero
// [RULE11] Freeze only while debug input held; resumes
module act_top (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatI,
    output logic      [31:0] wbDatO,
    output logic             wbAck,
    input  wire logic        dbgFreeze,
    input  wire logic        compareMatch,
    output logic             sampleActive,
    output logic             convertActive,
    output logic             convClk,
    output logic      [7:0]  digInEn,
    output logic             irq
);
    // ************************************************************
    // Bus decode
    // ************************************************************
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    wire         access   = wbCyc && wbStb && !ack_q;
    wire         wrLow    = access && wbWe && wbSel[0];
    wire         selCtrl  = (wbAdr == act_pkg::ADDR_CTRL);
    wire         selTim   = (wbAdr == act_pkg::ADDR_TIMING);
    wire         selDien  = (wbAdr == act_pkg::ADDR_DIEN);
    wire         selStat  = (wbAdr == act_pkg::ADDR_STATUS);
    wire         selMask  = (wbAdr == act_pkg::ADDR_MASK);
    wire         selState = (wbAdr == act_pkg::ADDR_STATE);
    wire         wrCtrl   = wrLow && selCtrl;
    wire         wrTim    = wrLow && selTim;
    wire         wrDien   = wrLow && selDien;
    wire         wrMask   = wrLow && selMask;
    wire         rdStat   = access && !wbWe && selStat;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] timing_q;
    logic [7:0] dien_q;
    logic [1:0] mask_q;
    logic [1:0] status_q;
    logic [1:0] status_d;

    wire        enable  = ctrl_q[act_pkg::CTRL_ENABLE];
    wire        seqIe   = ctrl_q[act_pkg::CTRL_SEQ_IE];
    wire        cmpIe   = ctrl_q[act_pkg::CTRL_CMP_IE];
    wire [1:0]  frzMode = ctrl_q[act_pkg::CTRL_FRZ_HI:act_pkg::CTRL_FRZ_LO];
    wire [4:0]  prsVal  = timing_q[act_pkg::TIM_PRS_LSB +: 5]; // [RULE5]
    wire [2:0]  smpSel  = timing_q[act_pkg::TIM_SMP_LSB +: 3]; // [RULE3]
    wire [4:0]  smpCyc  = act_pkg::smpLen(smpSel); // [RULE4]

    // Start is a command bit and never stored
    assign ctrl_d = {wbDatI[7:2], 1'b0, wbDatI[0]};

    // ************************************************************
    // Sequencer
    // ************************************************************
    act_pkg::act_state_e state_q;
    act_pkg::act_state_e state_d;
    logic [4:0] phase_q;
    logic [4:0] phase_d;
    logic [1:0] idx_q;
    logic [1:0] idx_d;
    logic       seqDoneEv;
    logic       convDoneEv;

    act_div_if dvIf ();

    wire startReq = wrCtrl && wbDatI[act_pkg::CTRL_START] && wbDatI[act_pkg::CTRL_ENABLE];
    wire abort    = wrTim && (wbAck == 1'b0); // [RULE2]
    wire frzImm   = (frzMode == act_pkg::FRZ_IMM);
    wire frzFin   = (frzMode == act_pkg::FRZ_FINISH);
    // Finish mode holds at the boundary before the next sample
    wire stall    = dbgFreeze && (frzImm || (frzFin && state_q == act_pkg::ST_SAMPLE
                    && phase_q == 5'h00)); // [RULE1] [RULE11]
    wire busy     = (state_q != act_pkg::ST_IDLE);
    wire step     = dvIf.tick && !stall;
    wire smpEnd   = (phase_q == smpCyc - 5'h01);
    wire convEnd  = (phase_q == act_pkg::CONV_CYCLES - 5'h01);

    assign dvIf.clear    = abort || !enable; // [RULE10]
    assign dvIf.run      = enable && busy && !stall; // [RULE1]
    assign dvIf.prescale = prsVal;

    act_clk_div u_div (
        .clock (clock),
        .rst_b (rst_b),
        .dv    (dvIf.div)
    );

    always_comb
    begin
        state_d    = state_q;
        phase_d    = phase_q;
        idx_d      = idx_q;
        seqDoneEv  = 1'b0;
        convDoneEv = 1'b0;
        if (!enable || abort)
        begin
            state_d = act_pkg::ST_IDLE; // [RULE7] [RULE10]
            phase_d = 5'h00;
            idx_d   = 2'h0;
        end
        else
        begin
            case (state_q)
                act_pkg::ST_IDLE:
                begin
                    if (startReq)
                    begin
                        state_d = act_pkg::ST_SAMPLE;
                        phase_d = 5'h00;
                        idx_d   = 2'h0;
                    end
                end
                act_pkg::ST_SAMPLE:
                begin
                    if (step)
                    begin
                        if (smpEnd)
                        begin
                            state_d = act_pkg::ST_CONV; // [RULE3]
                            phase_d = 5'h00;
                        end
                        else
                        begin
                            phase_d = phase_q + 5'h01;
                        end
                    end
                end
                default:
                begin
                    if (step)
                    begin
                        if (convEnd)
                        begin
                            convDoneEv = 1'b1;
                            phase_d    = 5'h00;
                            if (idx_q == act_pkg::SEQ_LAST)
                            begin
                                state_d   = act_pkg::ST_IDLE;
                                seqDoneEv = 1'b1;
                            end
                            else
                            begin
                                state_d = act_pkg::ST_SAMPLE;
                                idx_d   = idx_q + 2'h1;
                            end
                        end
                        else
                        begin
                            phase_d = phase_q + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Status, interrupt and read data
    // ************************************************************
    wire [1:0] events  = {convDoneEv && compareMatch, seqDoneEv};
    wire [1:0] localEn = {cmpIe, seqIe};
    // Set wins over the read clear
    assign status_d = (status_q & ~(rdStat ? 2'h3 : 2'h0)) | events;
    wire irq_d = |(status_q & mask_q & localEn); // [RULE8]

    assign rdat_d = selCtrl  ? {24'h000000, ctrl_q} :
                    selTim   ? {24'h000000, timing_q} :
                    selDien  ? {24'h000000, dien_q} :
                    selStat  ? {30'h0, status_q} :
                    selMask  ? {30'h0, mask_q} :
                    selState ? {24'h000000, idx_q, dbgFreeze && stall, busy, 2'h0, state_q} :
                    32'h00000000;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_q    <= 1'b0;
            rdat_q   <= 32'h00000000;
            ctrl_q   <= act_pkg::CTRL_RESET; // [RULE7]
            timing_q <= act_pkg::TIMING_RESET;
            dien_q   <= act_pkg::DIEN_RESET;
            mask_q   <= act_pkg::MASK_RESET;
            status_q <= 2'h0;
            state_q  <= act_pkg::ST_IDLE;
            phase_q  <= 5'h00;
            idx_q    <= 2'h0;
            irq      <= 1'b0;
        end
        else
        begin
            ack_q    <= access;
            rdat_q   <= access ? rdat_d : rdat_q;
            ctrl_q   <= wrCtrl ? ctrl_d : ctrl_q;
            timing_q <= wrTim ? wbDatI[7:0] : timing_q;
            dien_q   <= wrDien ? wbDatI[7:0] : dien_q; // [RULE9]
            mask_q   <= wrMask ? wbDatI[1:0] : mask_q;
            status_q <= status_d;
            state_q  <= state_d;
            phase_q  <= phase_d;
            idx_q    <= idx_d;
            irq      <= irq_d; // [RULE8]
        end
    end

    // ************************************************************
    // Flopped outputs to the converter core
    // ************************************************************
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sampleActive  <= 1'b0;
            convertActive <= 1'b0;
        end
        else
        begin
            sampleActive  <= (state_d == act_pkg::ST_SAMPLE);
            convertActive <= (state_d == act_pkg::ST_CONV);
        end
    end

    assign wbAck   = ack_q;
    assign wbDatO  = rdat_q;
    assign convClk = dvIf.convClk;
    assign digInEn = dien_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_timWrite;
        wbCyc && wbStb && wbWe && wbSel[0] && selTim && !ack_q;
    endsequence
    sequence s_backIdle;
        (state_q == act_pkg::ST_IDLE) && (phase_q == 5'h00) ##1 !sampleActive;
    endsequence

    a_abort_idle: assert property (@(posedge clock) disable iff (!rst_b) // [RULE2]
        s_timWrite |=> s_backIdle)
        else $error("timing write did not abort the sequence");
    a_abort_restart: assert property (@(posedge clock) disable iff (!rst_b) // [RULE10]
        s_timWrite |=> !convClk && !dvIf.tick)
        else $error("prescaler not restarted after abort");
    a_sample_len: assert property (@(posedge clock) disable iff (!rst_b) // [RULE4]
        (state_q == act_pkg::ST_SAMPLE && step && !abort && enable)
        |=> (state_q == act_pkg::ST_CONV) == $past(phase_q == smpCyc - 5'h01))
        else $error("sampling phase length wrong");
    a_freeze_hold: assert property (@(posedge clock) disable iff (!rst_b) // [RULE1]
        (dbgFreeze && frzImm && busy && !abort && enable && !wrCtrl)
        |=> $stable(phase_q) && $stable(state_q))
        else $error("immediate freeze did not hold");
    a_freeze_finish: assert property (@(posedge clock) disable iff (!rst_b) // [RULE1]
        (dbgFreeze && frzFin && enable && state_q == act_pkg::ST_CONV && !wrCtrl && !abort)
        |-> dvIf.run)
        else $error("finish mode froze inside a conversion");
    a_power_down: assert property (@(posedge clock) disable iff (!rst_b) // [RULE7]
        !enable |=> (state_q == act_pkg::ST_IDLE) && !sampleActive ##1 !convertActive)
        else $error("disabled converter not in power down");
    a_irq_gate: assert property (@(posedge clock) disable iff (!rst_b) // [RULE8]
        irq |-> $past(|(status_q & mask_q & localEn)))
        else $error("interrupt without enabled source");
    a_dien_write: assert property (@(posedge clock) disable iff (!rst_b) // [RULE9]
        (wrDien) |=> digInEn == $past(wbDatI[7:0]))
        else $error("input buffer mask not applied");
endmodule // act_top
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench of the conversion timing control block
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        samplesChecked++; \
        if ((got) !== (exp)) \
        begin \
            errorCnt++; \
            $display("BAD %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock;
    logic        rst_b;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [7:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatI;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        dbgFreeze;
    logic        compareMatch;
    logic        matchEn;
    logic        sampleActive;
    logic        convertActive;
    logic        convClk;
    logic [7:0]  digInEn;
    logic        irq;
    logic [31:0] rd;
    logic [31:0] sv;
    logic [7:0]  v;
    int          errorCnt;
    int          samplesChecked;
    int          seed;
    int          n;

    act_top DUT (.clock(clock), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
        .dbgFreeze(dbgFreeze), .compareMatch(compareMatch), .sampleActive(sampleActive),
        .convertActive(convertActive), .convClk(convClk), .digInEn(digInEn), .irq(irq));
    act_core_model core (.clock(clock), .rst_b(rst_b), .convertActive(convertActive),
        .matchEn(matchEn), .compareMatch(compareMatch));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic int expSmp(input logic [2:0] sel);
        int t[8] = '{4, 6, 8, 10, 12, 16, 20, 24};
        return t[sel];
    endfunction

    function automatic logic pick(input int w);
        return (w == 0) ? sampleActive : (w == 1) ? convertActive : convClk;
    endfunction

    task automatic final_report;
        if (errorCnt == 0 && samplesChecked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic expire;
        errorCnt++;
        final_report();
    endtask

    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] dat);
        int k = 0;
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatI <= dat;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (wbAck !== 1'b1 && k < 50);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (k >= 50)
            expire();
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        wbXfer(1'b1, adr, 4'hf, {24'h0, dat});
    endtask

    task automatic rdReg(input logic [7:0] adr);
        wbXfer(1'b0, adr, 4'hf, 32'h0);
    endtask

    // Waits until a watched output reaches a level; c counts the edges spent
    task automatic waitFor(input int w, input logic lvl, output int c);
        c = 0;
        while (pick(w) !== lvl && c < 3000)
        begin
            @(posedge clock);
            c++;
        end
        if (c >= 3000)
            expire();
    endtask

    task automatic waitIdle;
        int k = 0;
        do
        begin
            rdReg(act_pkg::ADDR_STATE);
            k++;
        end
        while (rd[4] !== 1'b0 && k < 300);
        if (k >= 300)
            expire();
    endtask

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        logic [7:0] ieT[4] = '{8'h0c, 8'h00, 8'h0c, 8'h04};
        logic [7:0] mkT[4] = '{8'h03, 8'h03, 8'h00, 8'h01};
        logic       mtT[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
        logic [1:0] stT[4] = '{2'h3, 2'h3, 2'h3, 2'h1};
        logic       irT[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        logic [1:0] mdT[3] = '{2'h1, 2'h3, 2'h2};
        logic [4:0] pT[2];
        seed = 82;
        errorCnt = 0;
        samplesChecked = 0;
        {wbCyc, wbStb, wbWe, dbgFreeze, matchEn} = 5'h00;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatI = 32'h0;
        rst_b = 1'b0;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        `CHK("idle outputs", 12'h000, {digInEn, irq, convClk, sampleActive, convertActive})
        for (int a = 0; a <= 8'h18; a += 4)
        begin
            rdReg(8'(a));
            `CHK("reset read", 32'h0, rd)
        end
        for (int i = 0; i < 3; i++)
        begin
            v = 8'($random(seed));
            wr(act_pkg::ADDR_DIEN, v);
            `CHK("buffer enables", v, digInEn)
            wbXfer(1'b1, act_pkg::ADDR_DIEN, 4'h0, {24'h0, ~v});
            rdReg(act_pkg::ADDR_DIEN);
            `CHK("enable readback", v, rd[7:0])
        end
        // Power up first: a start written while still powered down is ignored
        wr(act_pkg::ADDR_CTRL, 8'h01);
        for (int s = 0; s < 8; s++)
        begin
            wr(act_pkg::ADDR_TIMING, {3'(s), 5'h00});
            rdReg(act_pkg::ADDR_TIMING);
            `CHK("timing readback", {3'(s), 5'h00}, rd[7:0])
            wr(act_pkg::ADDR_CTRL, 8'h03);
            waitFor(1, 1'b1, n);
            waitFor(0, 1'b1, n);
            waitFor(0, 1'b0, n);
            `CHK("sample length", expSmp(3'(s)) * 2, n)
        end
        pT[0] = 5'h1f;
        pT[1] = 5'($random(seed));
        for (int i = 0; i < 2; i++)
        begin
            wr(act_pkg::ADDR_TIMING, {3'h0, pT[i]});
            wr(act_pkg::ADDR_CTRL, 8'h03);
            waitFor(2, 1'b1, n);
            waitFor(2, 1'b0, n);
            `CHK("clock high half", int'(pT[i]) + 1, n)
            waitFor(2, 1'b1, n);
            `CHK("clock low half", int'(pT[i]) + 1, n)
        end
        wr(act_pkg::ADDR_TIMING, 8'he1);
        wr(act_pkg::ADDR_CTRL, 8'h03);
        waitFor(0, 1'b1, n);
        wr(act_pkg::ADDR_TIMING, 8'($random(seed)));
        @(posedge clock);
        `CHK("abort outputs", 3'h0, {sampleActive, convertActive, convClk})
        rdReg(act_pkg::ADDR_STATE);
        `CHK("abort state", 5'h00, rd[4:0])
        rdReg(act_pkg::ADDR_STATUS);
        `CHK("abort status", 32'h0, rd)
        for (int i = 0; i < 4; i++)
        begin
            matchEn <= mtT[i];
            wr(act_pkg::ADDR_TIMING, 8'h00);
            rdReg(act_pkg::ADDR_STATUS);
            wr(act_pkg::ADDR_MASK, mkT[i]);
            wr(act_pkg::ADDR_CTRL, 8'h03 | ieT[i]);
            waitIdle();
            repeat (2) @(posedge clock);
            `CHK("irq raised", irT[i], irq)
            rdReg(act_pkg::ADDR_STATUS);
            `CHK("status flags", stT[i], rd[1:0])
            repeat (2) @(posedge clock);
            `CHK("irq cleared", 1'b0, irq)
        end
        matchEn <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            wr(act_pkg::ADDR_TIMING, 8'he0);
            rdReg(act_pkg::ADDR_STATUS);
            wr(act_pkg::ADDR_CTRL, 8'h03 | {2'h0, mdT[i], 4'h0});
            waitFor(0, 1'b1, n);
            dbgFreeze <= 1'b1;
            repeat (150) @(posedge clock);
            rdReg(act_pkg::ADDR_STATE);
            sv = rd;
            repeat (20) @(posedge clock);
            rdReg(act_pkg::ADDR_STATE);
            `CHK("frozen flag", mdT[i] != 2'h1, rd[5])
            if (mdT[i] != 2'h1)
                `CHK("held state", sv, rd)
            if (mdT[i] == 2'h3)
                `CHK("held in sample", 1'b1, sampleActive)
            dbgFreeze <= 1'b0;
            waitIdle();
            rdReg(act_pkg::ADDR_STATUS);
            `CHK("resumed to done", 1'b1, rd[0])
        end
        final_report();
    end
endmodule // tb_top
`default_nettype wire
